// ### rtl/rbc_regs.sv
// regulator b control register bank with decoded regulator controls
`timescale 1ns/1ps
`default_nettype none
`include "rbc_map.svh"

// Contract
// - Regulator A sleep voltage code decodes as 0.90 V to 1.60 V in 50 mV steps, then 1.70 V to 3.30 V in 100 mV steps.
// - On undervoltage of regulator B the error-action code ignores (00), shuts the regulator (01), resets the system (10), or is reserved (11).
// - Every regulator B undervoltage event sets the interrupt status regardless of the error action; irq follows it only while the mask bit is 1.
// - Hardware-control source selects none (00), input 1 (01), input 2 (10), or either (11), resetting to 00.
// - Under hardware control the voltage comes from the ON code when the choice bit is 0 and the sleep code when 1.
// - Under hardware control the mode is low power for 00 and 10, off for 01, and follows the ON mode bit for 11, resetting to 10.
// - A disabled regulator is discharged when float is 0 and floats when 1, and switch mode is a separate bit, both resetting to 0.
// - The low-power select bit picks the 50 mA variant at 0 and the 20 mA variant at 1 wherever low power applies.
// - Startup slot 000 never enables outside hardware control, 001-101 enable in slots 1-5, 110 follows enable input 1 and 111 enable input 2.
// - In the ON state the regulator runs normal at mode bit 0 and low power at 1.
// - The ON voltage code uses the same map, 00h 0.90 V, 0Eh 1.60 V, 0Fh 1.70 V, 1Fh 3.30 V, resetting to zero.
// - Sleep slot 000 transitions in slot 5, 001-101 disable in slots 5 down to 1, 110 transitions in slot 3, 111 in slot 1.
// - Regulator B holds a sleep voltage code with the same map used in sleep and when hardware control picks it.
module rbc_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire rbc_pkg::rbc_word_t reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output rbc_pkg::rbc_word_t reg_rdata,
	// sequencer and pins
	input wire logic [2:0] seq_timeslot,
	input wire logic seq_sleep,
	input wire logic undervoltage_pin,
	input wire logic hardware_control_1_pin,
	input wire logic hardware_control_2_pin,
	input wire logic hw_enable_1_pin,
	input wire logic hw_enable_2_pin,
	// regulator controls
	output logic reg_b_enable,
	output logic reg_b_low_power,
	output logic reg_b_low_power_variant,
	output logic reg_b_discharge,
	output logic reg_b_switch_mode,
	output rbc_pkg::rbc_mv_t reg_b_target_mv,
	output rbc_pkg::rbc_mv_t reg_a_sleep_mv,
	output logic system_reset_req,
	output logic irq
);
	import rbc_pkg::*;

	// ==========================================================
	// helpers
	// piecewise linear code to millivolt map
	function automatic rbc_mv_t code_to_mv(input logic [4:0] code);
		rbc_mv_t c;
		c = {7'h00, code};
		if (code <= `RBC_CODE_KNEE - 5'h01)
			code_to_mv = rbc_mv_t'(`RBC_MV_BASE + c * `RBC_MV_STEP_FINE);
		else
			code_to_mv = rbc_mv_t'(`RBC_MV_KNEE + (c - 12'd15) * `RBC_MV_STEP_COARSE);
	endfunction

	function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
		hit = (addr == target);
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [4:0] pins_s;
	rbc_sync #(.WIDTH(5)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({hw_enable_2_pin, hw_enable_1_pin, hardware_control_2_pin,
			hardware_control_1_pin, undervoltage_pin}),
		.sync_out(pins_s)
	);
	logic uv_s, hwc1_s, hwc2_s, hwen1_s, hwen2_s;
	assign uv_s = pins_s[0];
	assign hwc1_s = pins_s[1];
	assign hwc2_s = pins_s[2];
	assign hwen1_s = pins_s[3];
	assign hwen2_s = pins_s[4];

	// ==========================================================
	// state
	typedef struct packed {
		rbc_word_t a_sleep;
		rbc_word_t b_ctrl;
		rbc_word_t b_on;
		rbc_word_t b_sleep;
		logic irq_status;
		logic irq_mask;
		logic uv_prev;
		logic started;
		rbc_state_e st;
		rbc_word_t rdata;
		logic enable;
		logic low_power;
		logic lp_variant;
		logic discharge;
		logic switch_mode;
		rbc_mv_t target_mv;
		rbc_mv_t a_mv;
		logic sys_reset;
		logic irq;
	} rbc_state_s;

	rbc_state_s r, next_r;

	// field views
	logic [1:0] err_act, hwc_src, hw_mode;
	logic hw_vsel, on_mode, hwc_active, want_on, uv_rise;
	logic [2:0] on_slot, slp_slot;
	logic in_sleep, slp_disable;

	always_comb begin
		err_act = r.b_ctrl[`RBC_ERR_HI:`RBC_ERR_LO];
		hwc_src = r.b_ctrl[`RBC_SRC_HI:`RBC_SRC_LO];
		hw_vsel = r.b_ctrl[`RBC_HWV_BIT];
		hw_mode = r.b_ctrl[`RBC_HWM_HI:`RBC_HWM_LO];
		on_slot = r.b_on[`RBC_SLOT_HI:`RBC_SLOT_LO];
		on_mode = r.b_on[`RBC_MODE_BIT];
		slp_slot = r.b_sleep[`RBC_SLOT_HI:`RBC_SLOT_LO];
		uv_rise = uv_s & ~r.uv_prev;
		// source selection of hardware control
		case (hwc_src)
			2'h1: hwc_active = hwc1_s;
			2'h2: hwc_active = hwc2_s;
			2'h3: hwc_active = hwc1_s | hwc2_s;
			default: hwc_active = 1'b0;
		endcase
		// startup assignment
		case (on_slot)
			3'h0: want_on = 1'b0;
			3'h6: want_on = hwen1_s;
			3'h7: want_on = hwen2_s;
			default: want_on = r.started;
		endcase
		// sleep entry: disable codes turn the regulator off once the slot is reached
		in_sleep = seq_sleep;
		slp_disable = 1'b0;
		case (slp_slot)
			3'h0: in_sleep = seq_sleep && (seq_timeslot <= 3'h5);
			3'h6: in_sleep = seq_sleep && (seq_timeslot <= 3'h3);
			3'h7: in_sleep = seq_sleep && (seq_timeslot <= 3'h1);
			default: slp_disable = seq_sleep && (seq_timeslot <= 3'h6 - slp_slot);
		endcase
	end

	always_comb begin
		next_r = r;
		next_r.uv_prev = uv_s;
		next_r.sys_reset = 1'b0;
		next_r.rdata = 16'h0000;
		// startup timeslot has been reached
		if (!seq_sleep && on_slot >= 3'h1 && on_slot <= 3'h5 && seq_timeslot >= on_slot)
			next_r.started = 1'b1;
		if (on_slot == 3'h0)
			next_r.started = 1'b0;
		// register writes, undocumented bits forced to zero
		if (reg_write) begin
			if (hit(reg_addr, `RBC_ADDR_A_SLEEP))
				next_r.a_sleep = reg_wdata & `RBC_MASK_A_SLEEP;
			if (hit(reg_addr, `RBC_ADDR_B_CTRL))
				next_r.b_ctrl = reg_wdata & `RBC_MASK_B_CTRL;
			if (hit(reg_addr, `RBC_ADDR_B_ON))
				next_r.b_on = reg_wdata & `RBC_MASK_B_ON;
			if (hit(reg_addr, `RBC_ADDR_B_SLEEP))
				next_r.b_sleep = reg_wdata & `RBC_MASK_B_SLEEP;
			if (hit(reg_addr, `RBC_ADDR_IRQ_MASK))
				next_r.irq_mask = reg_wdata[0];
			if (hit(reg_addr, `RBC_ADDR_IRQ_STATUS) && reg_wdata[0])
				next_r.irq_status = 1'b0;
		end
		// set wins over write-one-to-clear
		if (uv_rise)
			next_r.irq_status = 1'b1;
		// register reads, one cycle later
		if (reg_read) begin
			if (hit(reg_addr, `RBC_ADDR_A_SLEEP))
				next_r.rdata = r.a_sleep;
			else if (hit(reg_addr, `RBC_ADDR_B_CTRL))
				next_r.rdata = r.b_ctrl;
			else if (hit(reg_addr, `RBC_ADDR_B_ON))
				next_r.rdata = r.b_on;
			else if (hit(reg_addr, `RBC_ADDR_B_SLEEP))
				next_r.rdata = r.b_sleep;
			else if (hit(reg_addr, `RBC_ADDR_IRQ_STATUS))
				next_r.rdata = {15'h0000, r.irq_status};
			else if (hit(reg_addr, `RBC_ADDR_IRQ_MASK))
				next_r.rdata = {15'h0000, r.irq_mask};
			else if (hit(reg_addr, `RBC_ADDR_B_STATE))
				next_r.rdata = {12'h000, r.st};
			else
				next_r.rdata = 16'h0000;
		end
		// regulator state machine
		case (r.st)
			RBC_ST_FAULT_OFF: begin
				// latched off until software rewrites the startup slot
				if (reg_write && hit(reg_addr, `RBC_ADDR_B_ON))
					next_r.st = RBC_ST_OFF;
			end
			RBC_ST_OFF, RBC_ST_NORMAL, RBC_ST_LOWPOWER: begin
				if (hwc_active) begin
					case (hw_mode)
						2'h1: next_r.st = RBC_ST_OFF;
						2'h3: next_r.st = on_mode ? RBC_ST_LOWPOWER : RBC_ST_NORMAL;
						default: next_r.st = RBC_ST_LOWPOWER;
					endcase
				end else if (!want_on || slp_disable) begin
					next_r.st = RBC_ST_OFF;
				end else if (in_sleep) begin
					next_r.st = r.b_sleep[`RBC_MODE_BIT] ? RBC_ST_LOWPOWER : RBC_ST_NORMAL;
				end else begin
					next_r.st = on_mode ? RBC_ST_LOWPOWER : RBC_ST_NORMAL;
				end
				if (uv_rise) begin
					case (err_act)
						RBC_ERR_REG_OFF: next_r.st = RBC_ST_FAULT_OFF;
						RBC_ERR_SYS_RESET: next_r.sys_reset = 1'b1;
						default: ;
					endcase
				end
			end
			default: next_r.st = RBC_ST_OFF;
		endcase
		// registered outputs
		next_r.enable = (r.st == RBC_ST_NORMAL) || (r.st == RBC_ST_LOWPOWER);
		next_r.low_power = (r.st == RBC_ST_LOWPOWER);
		next_r.lp_variant = r.b_ctrl[`RBC_LP_BIT];
		next_r.discharge = !next_r.enable && !r.b_ctrl[`RBC_FLT_BIT];
		next_r.switch_mode = r.b_ctrl[`RBC_SWI_BIT];
		if ((hwc_active && hw_vsel) || (!hwc_active && in_sleep))
			next_r.target_mv = code_to_mv(r.b_sleep[`RBC_VSEL_HI:`RBC_VSEL_LO]);
		else
			next_r.target_mv = code_to_mv(r.b_on[`RBC_VSEL_HI:`RBC_VSEL_LO]);
		next_r.a_mv = code_to_mv(r.a_sleep[`RBC_VSEL_HI:`RBC_VSEL_LO]);
		next_r.irq = r.irq_status & r.irq_mask;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.a_sleep <= `RBC_RST_A_SLEEP;
			r.b_ctrl <= `RBC_RST_B_CTRL;
			r.b_on <= `RBC_RST_B_ON;
			r.b_sleep <= `RBC_RST_B_SLEEP;
			r.irq_mask <= 1'b0;
			r.st <= RBC_ST_OFF;
			r.discharge <= 1'b1;
			r.target_mv <= `RBC_MV_BASE;
			r.a_mv <= `RBC_MV_BASE;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = r.rdata;
	assign reg_b_enable = r.enable;
	assign reg_b_low_power = r.low_power;
	assign reg_b_low_power_variant = r.lp_variant;
	assign reg_b_discharge = r.discharge;
	assign reg_b_switch_mode = r.switch_mode;
	assign reg_b_target_mv = r.target_mv;
	assign reg_a_sleep_mv = r.a_mv;
	assign system_reset_req = r.sys_reset;
	assign irq = r.irq;
endmodule // rbc_regs
`default_nettype wire

// ### rtl/rbc_map.svh
// register map, field positions, reset values and decode constants for regulator b control
`ifndef RBC_MAP_SVH
`define RBC_MAP_SVH

// ==========================================================
// register offsets
`define RBC_ADDR_A_SLEEP 16'h4070
`define RBC_ADDR_B_CTRL 16'h4071
`define RBC_ADDR_B_ON 16'h4072
`define RBC_ADDR_B_SLEEP 16'h4073
`define RBC_ADDR_IRQ_STATUS 16'h4100
`define RBC_ADDR_IRQ_MASK 16'h4101
`define RBC_ADDR_B_STATE 16'h4102

// ==========================================================
// read masks of implemented bits
`define RBC_MASK_A_SLEEP 16'h001F
`define RBC_MASK_B_CTRL 16'hDFC1
`define RBC_MASK_B_ON 16'hE11F
`define RBC_MASK_B_SLEEP 16'hE11F
`define RBC_MASK_IRQ 16'h0001

// ==========================================================
// reset values
`define RBC_RST_A_SLEEP 16'h0000
`define RBC_RST_B_CTRL 16'h0200
`define RBC_RST_B_ON 16'h0000
`define RBC_RST_B_SLEEP 16'h0100
`define RBC_RST_IRQ_MASK 16'h0000

// ==========================================================
// field positions
`define RBC_ERR_HI 15
`define RBC_ERR_LO 14
`define RBC_SRC_HI 12
`define RBC_SRC_LO 11
`define RBC_HWV_BIT 10
`define RBC_HWM_HI 9
`define RBC_HWM_LO 8
`define RBC_FLT_BIT 7
`define RBC_SWI_BIT 6
`define RBC_LP_BIT 0
`define RBC_SLOT_HI 15
`define RBC_SLOT_LO 13
`define RBC_MODE_BIT 8
`define RBC_VSEL_HI 4
`define RBC_VSEL_LO 0

// ==========================================================
// voltage decode in millivolts
`define RBC_MV_BASE 12'd900
`define RBC_MV_STEP_FINE 12'd50
`define RBC_MV_STEP_COARSE 12'd100
`define RBC_MV_KNEE 12'd1700
`define RBC_CODE_KNEE 5'h0F

`endif

// ### rtl/rbc_pkg.sv
// types shared by the regulator b control block
package rbc_pkg;
	typedef logic [15:0] rbc_word_t;
	typedef logic [11:0] rbc_mv_t;
	typedef enum logic [1:0] {
		RBC_ERR_IGNORE = 2'h0,
		RBC_ERR_REG_OFF = 2'h1,
		RBC_ERR_SYS_RESET = 2'h2,
		RBC_ERR_RESERVED = 2'h3
	} rbc_err_e;
	typedef enum logic [3:0] {
		RBC_ST_OFF = 4'h1,
		RBC_ST_NORMAL = 4'h2,
		RBC_ST_LOWPOWER = 4'h4,
		RBC_ST_FAULT_OFF = 4'h8
	} rbc_state_e;
endpackage

// ### rtl/rbc_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module rbc_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// pins and synchronised levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // rbc_sync
`default_nettype wire

// ### tb/rbc_regs_monitor.sv
// assertion checker for the regulator b control register bank
`timescale 1ns/1ps
`default_nettype none
module rbc_regs_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire rbc_pkg::rbc_word_t reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire rbc_pkg::rbc_word_t reg_rdata,
	// pins and controls
	input wire logic undervoltage_pin,
	input wire logic reg_b_enable,
	input wire logic reg_b_discharge,
	input wire rbc_pkg::rbc_mv_t reg_a_sleep_mv,
	input wire logic system_reset_req,
	input wire logic irq
);
	import rbc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// ==========
	// register port
	property p_rdata_idle;
		!$past(reg_read) |-> reg_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
	property p_readback;
		(reg_write && reg_addr == 16'h4072) ##1 (reg_read && reg_addr == 16'h4072)
			|=> reg_rdata == ($past(reg_wdata, 2) & 16'hE11F);
	endproperty
	a_readback: assert property (p_readback) else $error("readback differs");
	// ==========
	// undervoltage response
	property p_rst_pulse;
		system_reset_req |=> !system_reset_req;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
	property p_rst_cause;
		system_reset_req |-> $past(undervoltage_pin, 2);
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("reset request uncaused");
	property p_irq_rise;
		$rose(irq) |-> $past(undervoltage_pin, 2) || $past(reg_write, 2);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt uncaused");
	property p_irq_clear;
		(reg_write && reg_addr == 16'h4100 && reg_wdata[0] && !undervoltage_pin
			&& !$past(undervoltage_pin, 4)) |-> ##2 !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");
	// ==========
	// regulator outputs
	property p_discharge;
		reg_b_discharge |-> !reg_b_enable;
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge while on");
	property p_a_mv;
		(reg_a_sleep_mv <= 12'd1600) ? (reg_a_sleep_mv >= 12'd900 && reg_a_sleep_mv % 50 == 0)
			: (reg_a_sleep_mv <= 12'd3300 && reg_a_sleep_mv % 100 == 0);
	endproperty
	a_a_mv: assert property (p_a_mv) else $error("sleep voltage off grid");
endmodule // rbc_regs_monitor
bind rbc_regs rbc_regs_monitor i_mon (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.undervoltage_pin(undervoltage_pin), .reg_b_enable(reg_b_enable), .irq(irq),
	.reg_b_discharge(reg_b_discharge), .reg_a_sleep_mv(reg_a_sleep_mv),
	.system_reset_req(system_reset_req));
`default_nettype wire

// ### tb/tb.sv
// self-checking testbench for the regulator b control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rbc_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, seq_sleep = 1'b0;
	logic undervoltage_pin = 1'b0, hardware_control_1_pin = 1'b0, hardware_control_2_pin = 1'b0;
	logic hw_enable_1_pin = 1'b0, hw_enable_2_pin = 1'b0;
	logic [2:0] seq_timeslot = 3'h0;
	logic [15:0] reg_addr = 16'h0000;
	rbc_word_t reg_wdata = 16'h0000, reg_rdata;
	logic reg_b_enable, reg_b_low_power, reg_b_low_power_variant, reg_b_discharge;
	logic reg_b_switch_mode, system_reset_req, irq;
	rbc_mv_t reg_b_target_mv, reg_a_sleep_mv;
	int errors = 0, num_checks = 0, n_rst = 0;
	rbc_regs i_rbc_regs (.*);
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (system_reset_req === 1'b1) begin
			n_rst++;
		end
	end
	// ==========
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cb(input logic got, input logic exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	function automatic logic [15:0] mv(input logic [4:0] c);
		return (c < 5'h0F) ? 16'(900 + 50 * c) : 16'(1700 + 100 * (c - 5'h0F));
	endfunction
	// ==========
	// scenarios
	task automatic t_regs();
		logic [15:0] a[4] = '{16'h4070, 16'h4071, 16'h4072, 16'h4073};
		logic [15:0] m[4] = '{16'h001F, 16'hDFC1, 16'hE11F, 16'hE11F};
		logic [15:0] r[4] = '{16'h0000, 16'h0200, 16'h0000, 16'h0100};
		chk({4'h0, reg_b_target_mv}, 16'd900);
		cb(reg_b_discharge, 1'b1);
		for (int i = 0; i < 4; i++) begin
			rd(a[i], r[i]);
			wr(a[i], 16'hFFFF);
			rd(a[i], m[i]);
		end
		wr(16'h4074, 16'hFFFF);
		rd(16'h4074, 16'h0000);
	endtask
	task automatic t_volts();
		logic [4:0] c[6] = '{5'h00, 5'h01, 5'h0E, 5'h0F, 5'h1E, 5'h1F};
		wr(16'h4071, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			wr(16'h4070, {11'h0, c[i]});
			wr(16'h4072, {11'h0, c[i]});
			cyc(4);
			chk({4'h0, reg_a_sleep_mv}, mv(c[i]));
			chk({4'h0, reg_b_target_mv}, mv(c[i]));
		end
	endtask
	task automatic t_enable();
		seq_timeslot <= 3'h2;
		wr(16'h4072, 16'h6000);
		cyc(4);
		cb(reg_b_enable, 1'b0);
		cb(reg_b_discharge, 1'b1);
		seq_timeslot <= 3'h3;
		cyc(4);
		cb(reg_b_enable, 1'b1);
		wr(16'h4072, 16'h6100);
		wr(16'h4071, 16'h0041);
		cyc(4);
		cb(reg_b_low_power, 1'b1);
		cb(reg_b_low_power_variant, 1'b1);
		cb(reg_b_switch_mode, 1'b1);
		for (int i = 0; i < 2; i++) begin
			wr(16'h4072, 16'h0000);
			wr(16'h4072, (i == 0) ? 16'hC000 : 16'hE000);
			cyc(6);
			cb(reg_b_enable, 1'b0);
			hw_enable_1_pin <= (i == 0);
			hw_enable_2_pin <= (i == 1);
			cyc(6);
			cb(reg_b_enable, 1'b1);
			hw_enable_1_pin <= 1'b0;
			hw_enable_2_pin <= 1'b0;
		end
	endtask
	task automatic t_hwc();
		wr(16'h4072, 16'h2000);
		wr(16'h4073, 16'h001F);
		wr(16'h4071, 16'h0F00);
		hardware_control_1_pin <= 1'b1;
		cyc(6);
		chk({4'h0, reg_b_target_mv}, 16'd3300);
		cb(reg_b_low_power, 1'b0);
		wr(16'h4071, 16'h0D00);
		cyc(4);
		cb(reg_b_enable, 1'b0);
		wr(16'h4071, 16'h1400);
		cyc(4);
		chk({4'h0, reg_b_target_mv}, 16'd900);
		hardware_control_2_pin <= 1'b1;
		cyc(6);
		chk({4'h0, reg_b_target_mv}, 16'd3300);
		cb(reg_b_low_power, 1'b1);
		hardware_control_1_pin <= 1'b0;
		hardware_control_2_pin <= 1'b0;
	endtask
	task automatic t_sleep();
		seq_timeslot <= 3'h5;
		seq_sleep <= 1'b1;
		cyc(4);
		chk({4'h0, reg_b_target_mv}, 16'd3300);
		cb(reg_b_enable, 1'b1);
		cb(reg_b_low_power, 1'b0);
		wr(16'h4073, 16'h2100);
		cyc(4);
		cb(reg_b_enable, 1'b0);
		rd(16'h4102, 16'h0001);
		seq_sleep <= 1'b0;
		cyc(4);
		cb(reg_b_enable, 1'b1);
	endtask
	task automatic t_uv();
		int n;
		wr(16'h4101, 16'h0001);
		rd(16'h4101, 16'h0001);
		for (int a = 0; a < 5; a++) begin
			wr(16'h4072, 16'h2000);
			wr(16'h4071, {a[1:0], 14'h0});
			if (a == 4) begin
				wr(16'h4101, 16'h0000);
			end
			n = n_rst;
			cyc(4);
			undervoltage_pin <= 1'b1;
			cyc(6);
			undervoltage_pin <= 1'b0;
			cyc(4);
			cb(irq, a != 4);
			cb(reg_b_enable, a != 1);
			chk(16'(n_rst - n), (a == 2) ? 16'h0001 : 16'h0000);
			rd(16'h4100, 16'h0001);
			wr(16'h4100, 16'h0001);
			cyc(2);
			cb(irq, 1'b0);
		end
		rd(16'h4100, 16'h0000);
	endtask
	// ==========
	// verdict and sequence
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		cyc(1);
		t_regs();
		t_volts();
		t_enable();
		t_hwc();
		t_sleep();
		t_uv();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
